/* tfac_defines.vh */
// Constants shared by the TLP formation and ACS checker files
`ifndef TFAC_DEFINES_VH
`define TFAC_DEFINES_VH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define TFAC_OFS_CTRL       4'h0
`define TFAC_OFS_IN_MAP     4'h1
`define TFAC_OFS_EG_MAP     4'h2
`define TFAC_OFS_SEV        4'h3
`define TFAC_OFS_EVT_STS    4'h4
`define TFAC_OFS_EVT_MASK   4'h5
`define TFAC_OFS_SEC_STS    4'h6
`define TFAC_OFS_LOG0       4'h8
`define TFAC_OFS_LOG1       4'h9
`define TFAC_OFS_LOG2       4'hA
`define TFAC_OFS_LOG3       4'hB

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TFAC_CTRL_DSP_BIT   0
`define TFAC_SEV_ACS_BIT    0
`define TFAC_SIGNALED_TARGET_ABORT_FLAG_BIT       11
`define TFAC_EVT_IN_MAL     0
`define TFAC_EVT_EG_MAL     1
`define TFAC_EVT_ACS        2
`define TFAC_EVT_ACS_ADV    3
`define TFAC_EVT_W          4
`define TFAC_MAP_RST        8'hFF
`define TFAC_SEV_RST        1'h1
`define TFAC_CTRL_RST       1'h0

// ----------------------------------------------------------------
// TLP routing sub-field codes
// ----------------------------------------------------------------
`define TFAC_RT_TO_RC       3'h0
`define TFAC_RT_BCAST       3'h3
`define TFAC_RT_LOCAL       3'h4
`define TFAC_RT_GATHER      3'h5
`define TFAC_TC_ZERO        3'h0

`endif

/* tfac_map_check.v */
// Traffic class to channel 0 map lookup
`default_nettype none

module tfac_map_check #(
    parameter TC_W = 3
) (
    // Map and class
    input  wire [(1<<TC_W)-1:0] class_to_channel_map,
    input  wire [TC_W-1:0]      tc,
    // Result
    output wire                 mapped
);

    wire [(1<<TC_W)-1:0] hit;
    wire [(1<<TC_W)-1:0] tc_sel = {{((1<<TC_W)-1){1'b0}}, 1'b1} << tc;

    genvar i;
    generate
        for (i = 0; i < (1 << TC_W); i = i + 1) begin : g_tc
            assign hit[i] = class_to_channel_map[i] && tc_sel[i];
        end
    endgenerate

    assign mapped = |hit;

endmodule

`default_nettype wire

/* tfac_checker.v */
// TLP formation and ACS violation checker for a switch bridge function
//
// Contract
// - Special message classes need traffic class zero
// - Route-to-root only on downstream ports
// - Broadcast routing only on upstream port
// - Gathered routing: downstream only, PME ack only
// - INTx messages only on downstream ports
// - Ingress class must map to channel 0
// - Egress class must map to channel 0
// - ACS checks only in downstream mode
// - ACS redirect is no error, no log
// - ACS block is a logged violation
// - No source validation on local/gathered messages
// - Non-posted violation returns completer abort completion
// - Violation sets signaled target abort flag
// - Advisory if non-fatal and non-posted, else uncorrectable
// - Log header and drop violating TLP
// - Direct translated treated as egress control
// - Ingress checks on every TLP from link
//
// Implementation choices: the address map and the Avalon-MM register port.
`include "tfac_defines.vh"
`default_nettype none

module tfac_checker #(
    parameter TC_W  = 3,
    parameter HDR_W = 128
) (
    // Clock and reset
    input  wire               CORE_CLK,
    input  wire               RST_B,
    // Avalon-MM register slave
    input  wire [3:0]         AVS_ADDRESS,
    input  wire               AVS_READ,
    input  wire               AVS_WRITE,
    input  wire [31:0]        AVS_WRITEDATA,
    input  wire [3:0]         AVS_BYTEENABLE,
    output reg  [31:0]        AVS_READDATA,
    output reg                AVS_WAITREQUEST,
    // Ingress TLP descriptor
    input  wire               IN_VLD,
    input  wire [HDR_W-1:0]   IN_HDR,
    input  wire [TC_W-1:0]    IN_TC,
    input  wire               IN_IS_MSG,
    input  wire [2:0]         IN_ROUTE,
    input  wire               IN_SPECIAL_MSG,
    input  wire               IN_IS_INTX,
    input  wire               IN_IS_PME_TO_ACK,
    input  wire               IN_NON_POSTED,
    // ACS check results for the ingress TLP
    input  wire               IN_ACS_SRC_FAIL,
    input  wire               IN_ACS_XLAT_FAIL,
    input  wire               IN_ACS_P2P_FAIL,
    input  wire               IN_ACS_DT_P2P_FAIL,
    input  wire               IN_ACS_REDIRECT,
    // Egress TLP descriptor
    input  wire               EG_VLD,
    input  wire [TC_W-1:0]    EG_TC,
    // Ingress decisions
    output reg                IN_FWD,
    output reg                IN_REDIRECT,
    output reg                IN_DROP,
    output reg                CPL_CA_REQ,
    // Error indications
    output reg                ERR_MALFORMED,
    output reg                ERR_ACS,
    output reg                ERR_ACS_ADVISORY,
    output reg                ERR_UNCORR,
    output reg                HDR_LOG_VLD,
    output reg                EG_MALFORMED,
    // Interrupt
    output reg                IRQ
);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    reg                       dsp_mode_q;
    reg  [(1<<TC_W)-1:0]      in_map_q;
    reg  [(1<<TC_W)-1:0]      eg_map_q;
    reg                       acs_sev_fatal_q;
    reg  [`TFAC_EVT_W-1:0]    evt_sts_q;
    reg  [`TFAC_EVT_W-1:0]    evt_sts_d;
    reg  [`TFAC_EVT_W-1:0]    evt_mask_q;
    reg                       signaled_target_abort_flag_q;
    reg  [HDR_W-1:0]          hdr_log_q;
    reg  [31:0]               rd_mux;

    wire in_mapped;
    wire eg_mapped;

    // ----------------------------------------------------------------
    // Traffic class map lookups
    // ----------------------------------------------------------------
    tfac_map_check #(
        .TC_W                 (TC_W)
    ) u_in_map (
        .class_to_channel_map (in_map_q),
        .tc                   (IN_TC),
        .mapped               (in_mapped)
    );

    tfac_map_check #(
        .TC_W                 (TC_W)
    ) u_eg_map (
        .class_to_channel_map (eg_map_q),
        .tc                   (EG_TC),
        .mapped               (eg_mapped)
    );

    // ----------------------------------------------------------------
    // Ingress formation checks
    // ----------------------------------------------------------------
    wire usp = ~dsp_mode_q;
    wire rt_rc     = IN_IS_MSG && (IN_ROUTE == `TFAC_RT_TO_RC);
    wire rt_bcast  = IN_IS_MSG && (IN_ROUTE == `TFAC_RT_BCAST);
    wire rt_local  = IN_IS_MSG && (IN_ROUTE == `TFAC_RT_LOCAL);
    wire rt_gather = IN_IS_MSG && (IN_ROUTE == `TFAC_RT_GATHER);

    wire mal_tc     = IN_IS_MSG && IN_SPECIAL_MSG
                      && (IN_TC != `TFAC_TC_ZERO);
    wire mal_rc     = rt_rc && usp;
    wire mal_bcast  = rt_bcast && dsp_mode_q;
    wire mal_gather = rt_gather && (usp || !IN_IS_PME_TO_ACK);
    wire mal_intx   = IN_IS_MSG && IN_IS_INTX && usp;
    wire mal_map    = !in_mapped;

    wire in_mal = mal_tc || mal_rc || mal_bcast || mal_gather
                  || mal_intx || mal_map;

    // ----------------------------------------------------------------
    // ACS violation checks
    // ----------------------------------------------------------------
    // Source validation is not supported on local or gathered messages
    wire src_ok_skip = rt_local || rt_gather;
    wire acs_src     = IN_ACS_SRC_FAIL && !src_ok_skip;
    // Direct translated peer traffic falls under egress control
    wire acs_p2p     = IN_ACS_P2P_FAIL || IN_ACS_DT_P2P_FAIL;
    wire acs_block   = dsp_mode_q
                       && (acs_src || IN_ACS_XLAT_FAIL || acs_p2p);
    wire acs_redir   = dsp_mode_q && IN_ACS_REDIRECT && !acs_block;
    wire acs_adv     = !acs_sev_fatal_q && IN_NON_POSTED;

    wire in_viol = IN_VLD && acs_block;
    wire in_bad  = IN_VLD && in_mal;

    // ----------------------------------------------------------------
    // Ingress and egress decision pulses
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            IN_FWD           <= 1'b0;
            IN_REDIRECT      <= 1'b0;
            IN_DROP          <= 1'b0;
            CPL_CA_REQ       <= 1'b0;
            ERR_MALFORMED    <= 1'b0;
            ERR_ACS          <= 1'b0;
            ERR_ACS_ADVISORY <= 1'b0;
            ERR_UNCORR       <= 1'b0;
            HDR_LOG_VLD      <= 1'b0;
            EG_MALFORMED     <= 1'b0;
        end else begin
            // Redirect is forwarded on another path and never logged
            IN_FWD           <= IN_VLD && !in_mal && !acs_block && !acs_redir;
            IN_REDIRECT      <= IN_VLD && !in_mal && acs_redir;
            IN_DROP          <= in_bad || in_viol;
            // Completer abort here is not counted as a completer error
            CPL_CA_REQ       <= in_viol && IN_NON_POSTED;
            ERR_MALFORMED    <= in_bad;
            ERR_ACS          <= in_viol;
            ERR_ACS_ADVISORY <= in_viol && acs_adv;
            ERR_UNCORR       <= in_bad || (in_viol && !acs_adv);
            HDR_LOG_VLD      <= in_bad || in_viol;
            EG_MALFORMED     <= EG_VLD && !eg_mapped;
        end
    end

    // ----------------------------------------------------------------
    // Header log
    // ----------------------------------------------------------------
    // Latest offending header wins; no first-error hold
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hdr_log_q <= {HDR_W{1'b0}};
        end else if (in_bad || in_viol) begin
            hdr_log_q <= IN_HDR;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM handshake
    // ----------------------------------------------------------------
    // Waitrequest drops for one cycle, the cycle after the request rises
    wire req    = AVS_READ || AVS_WRITE;
    wire accept = req && !AVS_WAITREQUEST;
    wire wr_acc = accept && AVS_WRITE;
    wire rd_acc = accept && AVS_READ;

    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        case (AVS_ADDRESS)
            `TFAC_OFS_CTRL: begin
                rd_mux[`TFAC_CTRL_DSP_BIT] = dsp_mode_q;
            end
            `TFAC_OFS_IN_MAP: begin
                rd_mux[(1<<TC_W)-1:0] = in_map_q;
            end
            `TFAC_OFS_EG_MAP: begin
                rd_mux[(1<<TC_W)-1:0] = eg_map_q;
            end
            `TFAC_OFS_SEV: begin
                rd_mux[`TFAC_SEV_ACS_BIT] = acs_sev_fatal_q;
            end
            `TFAC_OFS_EVT_STS: begin
                rd_mux[`TFAC_EVT_W-1:0] = evt_sts_q;
            end
            `TFAC_OFS_EVT_MASK: begin
                rd_mux[`TFAC_EVT_W-1:0] = evt_mask_q;
            end
            `TFAC_OFS_SEC_STS: begin
                rd_mux[`TFAC_SIGNALED_TARGET_ABORT_FLAG_BIT] = signaled_target_abort_flag_q;
            end
            `TFAC_OFS_LOG0: begin
                rd_mux = hdr_log_q[31:0];
            end
            `TFAC_OFS_LOG1: begin
                rd_mux = hdr_log_q[63:32];
            end
            `TFAC_OFS_LOG2: begin
                rd_mux = hdr_log_q[95:64];
            end
            `TFAC_OFS_LOG3: begin
                rd_mux = hdr_log_q[127:96];
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Data settles the edge waitrequest falls, held through acceptance
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            AVS_READDATA <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Configuration writes
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dsp_mode_q      <= `TFAC_CTRL_RST;
            in_map_q        <= `TFAC_MAP_RST;
            eg_map_q        <= `TFAC_MAP_RST;
            acs_sev_fatal_q <= `TFAC_SEV_RST;
            evt_mask_q      <= {`TFAC_EVT_W{1'b0}};
        end else if (wr_acc && AVS_BYTEENABLE[0]) begin
            case (AVS_ADDRESS)
                `TFAC_OFS_CTRL: begin
                    dsp_mode_q <= AVS_WRITEDATA[`TFAC_CTRL_DSP_BIT];
                end
                `TFAC_OFS_IN_MAP: begin
                    in_map_q <= AVS_WRITEDATA[(1<<TC_W)-1:0];
                end
                `TFAC_OFS_EG_MAP: begin
                    eg_map_q <= AVS_WRITEDATA[(1<<TC_W)-1:0];
                end
                `TFAC_OFS_SEV: begin
                    acs_sev_fatal_q <= AVS_WRITEDATA[`TFAC_SEV_ACS_BIT];
                end
                `TFAC_OFS_EVT_MASK: begin
                    evt_mask_q <= AVS_WRITEDATA[`TFAC_EVT_W-1:0];
                end
                default: begin
                    dsp_mode_q <= dsp_mode_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Secondary side status: signaled target abort, write one to clear
    // ----------------------------------------------------------------
    wire signaled_target_abort_flag_clr = wr_acc && AVS_BYTEENABLE[1]
                    && (AVS_ADDRESS == `TFAC_OFS_SEC_STS)
                    && AVS_WRITEDATA[`TFAC_SIGNALED_TARGET_ABORT_FLAG_BIT];

    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            signaled_target_abort_flag_q <= 1'b0;
        end else if (in_viol) begin
            // A new violation beats a clear in the same cycle
            signaled_target_abort_flag_q <= 1'b1;
        end else if (signaled_target_abort_flag_clr) begin
            signaled_target_abort_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Event status, read to clear, and interrupt
    // ----------------------------------------------------------------
    wire [`TFAC_EVT_W-1:0] evt_set;

    assign evt_set[`TFAC_EVT_IN_MAL]  = in_bad;
    assign evt_set[`TFAC_EVT_EG_MAL]  = EG_VLD && !eg_mapped;
    assign evt_set[`TFAC_EVT_ACS]     = in_viol;
    assign evt_set[`TFAC_EVT_ACS_ADV] = in_viol && acs_adv;

    always @* begin
        evt_sts_d = evt_sts_q;
        if (rd_acc && (AVS_ADDRESS == `TFAC_OFS_EVT_STS)) begin
            evt_sts_d = evt_sts_q & ~AVS_READDATA[`TFAC_EVT_W-1:0];
        end
        evt_sts_d = evt_sts_d | evt_set;
    end

    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            evt_sts_q <= {`TFAC_EVT_W{1'b0}};
            IRQ       <= 1'b0;
        end else begin
            evt_sts_q <= evt_sts_d;
            IRQ       <= |(evt_sts_d & evt_mask_q);
        end
    end

endmodule

`default_nettype wire

/* tfac_checker_dummy_guard.v */
// Spare file, holds no logic
`default_nettype none
`default_nettype wire

/* tfac_checker_chk.sv */
// Port-level assertions for the TLP formation and ACS checker
`include "tfac_defines.vh"
`default_nettype none
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module tfac_checker_chk #(
    parameter TC_W = 3
) (
    // Clock, reset and bus
    input wire logic            CORE_CLK,
    input wire logic            RST_B,
    input wire logic [3:0]      AVS_ADDRESS,
    input wire logic            AVS_READ,
    input wire logic            AVS_WRITE,
    input wire logic [31:0]     AVS_WRITEDATA,
    input wire logic [3:0]      AVS_BYTEENABLE,
    input wire logic            AVS_WAITREQUEST,
    // Ingress and egress descriptors
    input wire logic            IN_VLD,
    input wire logic [TC_W-1:0] IN_TC,
    input wire logic            IN_IS_MSG,
    input wire logic [2:0]      IN_ROUTE,
    input wire logic            IN_SPECIAL_MSG,
    input wire logic            IN_IS_INTX,
    input wire logic            IN_IS_PME_TO_ACK,
    input wire logic            IN_NON_POSTED,
    input wire logic            IN_ACS_SRC_FAIL,
    input wire logic            IN_ACS_XLAT_FAIL,
    input wire logic            IN_ACS_P2P_FAIL,
    input wire logic            IN_ACS_DT_P2P_FAIL,
    input wire logic            IN_ACS_REDIRECT,
    input wire logic            EG_VLD,
    input wire logic [TC_W-1:0] EG_TC,
    // Decisions and errors
    input wire logic            IN_FWD,
    input wire logic            IN_REDIRECT,
    input wire logic            IN_DROP,
    input wire logic            CPL_CA_REQ,
    input wire logic            ERR_MALFORMED,
    input wire logic            ERR_ACS,
    input wire logic            ERR_ACS_ADVISORY,
    input wire logic            ERR_UNCORR,
    input wire logic            HDR_LOG_VLD,
    input wire logic            EG_MALFORMED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    logic       dsp_q;
    logic       sev_q;
    logic [7:0] imap_q;
    logic [7:0] emap_q;
    wire logic wr_acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    // Shadow of the configuration, updated at the accepting edge
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dsp_q <= 1'b0;
            sev_q <= 1'b1;
            imap_q <= 8'hFF;
            emap_q <= 8'hFF;
        end else if (wr_acc) begin
            if (AVS_ADDRESS == `TFAC_OFS_CTRL) dsp_q <= AVS_WRITEDATA[0];
            if (AVS_ADDRESS == `TFAC_OFS_SEV) sev_q <= AVS_WRITEDATA[0];
            if (AVS_ADDRESS == `TFAC_OFS_IN_MAP) imap_q <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == `TFAC_OFS_EG_MAP) emap_q <= AVS_WRITEDATA[7:0];
        end
    end
    wire logic lcl = IN_IS_MSG && (IN_ROUTE == 3'h4 || IN_ROUTE == 3'h5);
    wire logic blk = dsp_q && (IN_ACS_XLAT_FAIL || IN_ACS_P2P_FAIL || IN_ACS_DT_P2P_FAIL
                     || (IN_ACS_SRC_FAIL && !lcl));
    wire logic mal = !imap_q[IN_TC] || (IN_IS_MSG && ((IN_SPECIAL_MSG && IN_TC != 0)
                     || (IN_ROUTE == 3'h0 && !dsp_q) || (IN_ROUTE == 3'h3 && dsp_q)
                     || (IN_ROUTE == 3'h5 && !(dsp_q && IN_IS_PME_TO_ACK))
                     || (IN_IS_INTX && !dsp_q)));
    sequence s_ack;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    sequence s_drop_log;
        IN_DROP && ERR_ACS && HDR_LOG_VLD;
    endsequence
    AST_BUS_ACK: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_ack)
        else $error("bus answer not one wait cycle");
    AST_ONE_DECISION: assert property (IN_VLD |=> $onehot({IN_FWD, IN_REDIRECT, IN_DROP}))
        else $error("ingress decision not unique");
    AST_MALFORMED: assert property (IN_VLD |=> ERR_MALFORMED == $past(mal))
        else $error("ingress malformed flag wrong");
    AST_EGRESS: assert property (1'b1 |=> EG_MALFORMED == $past(EG_VLD && !emap_q[EG_TC]))
        else $error("egress malformed flag wrong");
    AST_NO_VIOL: assert property (IN_VLD && !blk |=> !ERR_ACS && !CPL_CA_REQ)
        else $error("violation without block");
    AST_BLOCK: assert property (IN_VLD && blk |=> s_drop_log)
        else $error("blocked TLP not dropped and logged");
    AST_REDIR: assert property (IN_VLD && dsp_q && IN_ACS_REDIRECT && !blk && !mal
        |=> IN_REDIRECT && !HDR_LOG_VLD && !ERR_ACS) else $error("redirect treated as error");
    AST_CPL_ABORT: assert property (IN_VLD && blk |=> CPL_CA_REQ == $past(IN_NON_POSTED))
        else $error("completer abort request wrong");
    AST_ADVISORY: assert property (IN_VLD && blk && !sev_q && IN_NON_POSTED
        |=> ERR_ACS_ADVISORY) else $error("advisory case missed");
    AST_NONADV: assert property (IN_VLD && blk && (sev_q || !IN_NON_POSTED)
        |=> ERR_UNCORR && !ERR_ACS_ADVISORY) else $error("non-advisory case wrong");
endmodule
`default_nettype wire

/* tfac_link_model.sv */
// Link-side source of ingress and egress TLP descriptors
`default_nettype none
module tfac_link_model (
    // Clock
    input wire logic    clk,
    // Ingress descriptor
    output logic         in_vld,
    output logic [127:0] in_hdr,
    output logic [2:0]   in_tc,
    output logic         in_is_msg,
    output logic [2:0]   in_route,
    output logic         in_special,
    output logic         in_intx,
    output logic         in_pme,
    output logic         in_np,
    output logic         in_src,
    output logic         in_xlat,
    output logic         in_p2p,
    output logic         in_dt,
    output logic         in_redir,
    // Egress descriptor
    output logic         eg_vld,
    output logic [2:0]   eg_tc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {in_vld, in_hdr, in_tc, in_is_msg, in_route, eg_vld, eg_tc} = '0;
        {in_special, in_intx, in_pme, in_np, in_src, in_xlat, in_p2p, in_dt, in_redir} = '0;
    end
    // Fields invert once released so stale values never look valid
    task send(input logic [15:0] d, input logic [127:0] h);
        @(posedge clk);
        in_vld <= 1'b1;
        in_hdr <= h;
        {in_tc, in_is_msg, in_route, in_special, in_intx, in_pme, in_np,
         in_src, in_xlat, in_p2p, in_dt, in_redir} <= d;
        @(posedge clk);
        in_vld <= 1'b0;
        in_hdr <= ~h;
        {in_tc, in_is_msg, in_route, in_special, in_intx, in_pme, in_np,
         in_src, in_xlat, in_p2p, in_dt, in_redir} <= ~d;
    endtask
    task eg(input logic [2:0] t);
        @(posedge clk);
        eg_vld <= 1'b1;
        eg_tc <= t;
        @(posedge clk);
        eg_vld <= 1'b0;
        eg_tc <= ~t;
    endtask
endmodule
`default_nettype wire

/* tfac_checker_bench.sv */
// Self-checking bench for the TLP formation and ACS checker
`include "tfac_defines.vh"
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t got %0h expected %0h", $time, (a), (e)); end end
module tfac_checker_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
    logic [3:0] adr = 4'h0, ben = 4'hF;
    logic [31:0] wdat = 32'h0, r;
    logic [23:0] n = 24'h0;
    logic [7:0] em = 8'h5A;
    int error_cnt = 0, comparisons = 0;
    wire logic [31:0] rdat;
    wire logic [127:0] in_hdr;
    wire logic [2:0] in_tc, in_route, eg_tc;
    wire logic wreq, in_vld, in_is_msg, in_special, in_intx, in_pme, in_np, in_src, in_xlat;
    wire logic in_p2p, in_dt, in_redir, eg_vld, fwd, redir, drop, ca, mal, acs, adv, unc;
    wire logic logv, egm, irq;
    always #5 clk = ~clk;
    tfac_link_model link (.*);
    tfac_checker #(.TC_W(3), .HDR_W(128)) uut (.CORE_CLK(clk), .RST_B(rst_b),
        .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(ben), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .IN_VLD(in_vld), .IN_HDR(in_hdr), .IN_TC(in_tc), .IN_IS_MSG(in_is_msg),
        .IN_ROUTE(in_route), .IN_SPECIAL_MSG(in_special), .IN_IS_INTX(in_intx),
        .IN_IS_PME_TO_ACK(in_pme), .IN_NON_POSTED(in_np), .IN_ACS_SRC_FAIL(in_src),
        .IN_ACS_XLAT_FAIL(in_xlat), .IN_ACS_P2P_FAIL(in_p2p), .IN_ACS_DT_P2P_FAIL(in_dt),
        .IN_ACS_REDIRECT(in_redir), .EG_VLD(eg_vld), .EG_TC(eg_tc), .IN_FWD(fwd),
        .IN_REDIRECT(redir), .IN_DROP(drop), .CPL_CA_REQ(ca), .ERR_MALFORMED(mal),
        .ERR_ACS(acs), .ERR_ACS_ADVISORY(adv), .ERR_UNCORR(unc), .HDR_LOG_VLD(logv),
        .EG_MALFORMED(egm), .IRQ(irq));
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_en <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        wr_en <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        adr <= a;
        rd_en <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdat;
        rd_en <= 1'b0;
        `CHK(r, e)
    endtask
    // Descriptor: tc, msg, route, special/intx/pme/np, src/xlat/p2p/dt/redirect
    // Expected: fwd, redirect, drop, abort cpl, malformed, acs, advisory, uncorr
    task tlp(input logic [15:0] d, input logic [7:0] e);
        n = n + 24'h1;
        link.send(d, {8'h44, n, 8'h33, n, 8'h22, n, 8'h11, n});
        #1;
        `CHK({fwd, redir, drop, ca, mal, acs, adv, unc}, e)
    endtask
    task irqc(input logic e);
        @(posedge clk);
        #1;
        `CHK(irq, e)
    endtask
    task results;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK({wreq, irq, mal, egm}, 4'h8)
        rdc(`TFAC_OFS_CTRL, 32'h0);
        rdc(`TFAC_OFS_IN_MAP, 32'hFF);
        rdc(`TFAC_OFS_EG_MAP, 32'hFF);
        rdc(`TFAC_OFS_SEV, 32'h1);
        rdc(`TFAC_OFS_EVT_MASK, 32'h0);
        rdc(`TFAC_OFS_SEC_STS, 32'h0);
        for (int k = 8; k < 12; k++) rdc(k[3:0], 32'h0);
        wr(4'h7, 32'hFFFF_FFFF);
        rdc(4'h7, 32'h0);
        rdc(4'hF, 32'h0);
        $display("Test registers done");
        tlp(16'b001_1_100_1000_00000, 8'b0010_1001);
        tlp(16'b000_1_100_1000_00000, 8'b1000_0000);
        tlp(16'b000_1_000_0000_00000, 8'b0010_1001);
        tlp(16'b000_1_011_0000_00000, 8'b1000_0000);
        tlp(16'b000_1_101_0010_00000, 8'b0010_1001);
        tlp(16'b000_1_100_0100_00000, 8'b0010_1001);
        tlp(16'b000_0_000_0001_11111, 8'b1000_0000);
        wr(`TFAC_OFS_IN_MAP, 32'hFD);
        tlp(16'b001_0_000_0000_00000, 8'b0010_1001);
        tlp(16'b010_0_000_0000_00000, 8'b1000_0000);
        wr(`TFAC_OFS_IN_MAP, 32'hFF);
        wr(`TFAC_OFS_EG_MAP, {24'h0, em});
        for (int t = 0; t < 8; t++) begin
            link.eg(t[2:0]);
            #1;
            `CHK(egm, ~em[t])
        end
        $display("Test upstream formation done");
        rdc(`TFAC_OFS_EVT_STS, 32'h3);
        rdc(`TFAC_OFS_EVT_STS, 32'h0);
        wr(`TFAC_OFS_EVT_MASK, 32'h1);
        link.eg(3'h0);
        irqc(1'b0);
        tlp(16'b000_1_000_0000_00000, 8'b0010_1001);
        irqc(1'b1);
        rdc(`TFAC_OFS_EVT_STS, 32'h3);
        irqc(1'b0);
        $display("Test interrupt done");
        wr(`TFAC_OFS_CTRL, 32'h1);
        tlp(16'b000_1_000_0000_00000, 8'b1000_0000);
        tlp(16'b000_1_011_0000_00000, 8'b0010_1001);
        tlp(16'b000_1_101_0010_00000, 8'b1000_0000);
        tlp(16'b000_1_101_0000_00000, 8'b0010_1001);
        tlp(16'b000_1_100_0100_00000, 8'b1000_0000);
        tlp(16'b000_0_000_0001_10000, 8'b0011_0101);
        tlp(16'b000_0_000_0000_01000, 8'b0010_0101);
        tlp(16'b000_0_000_0001_00100, 8'b0011_0101);
        tlp(16'b000_0_000_0001_00010, 8'b0011_0101);
        tlp(16'b000_1_100_0100_10000, 8'b1000_0000);
        tlp(16'b000_1_101_0010_10000, 8'b1000_0000);
        tlp(16'b000_0_000_0001_00001, 8'b0100_0000);
        tlp(16'b000_0_000_0001_00101, 8'b0011_0101);
        wr(`TFAC_OFS_SEV, 32'h0);
        tlp(16'b000_0_000_0000_10000, 8'b0010_0101);
        tlp(16'b000_0_000_0001_10000, 8'b0011_0110);
        for (int k = 0; k < 4; k++) rdc(4'h8 + k[3:0], {8'(8'h11 * (k + 1)), n});
        rdc(`TFAC_OFS_SEC_STS, 32'h800);
        ben <= 4'h1;
        wr(`TFAC_OFS_SEC_STS, 32'h800);
        rdc(`TFAC_OFS_SEC_STS, 32'h800);
        ben <= 4'hF;
        wr(`TFAC_OFS_SEC_STS, 32'h800);
        rdc(`TFAC_OFS_SEC_STS, 32'h0);
        rdc(`TFAC_OFS_EVT_STS, 32'hD);
        $display("Test downstream ACS done");
        results;
    end
    // Whole run is about two hundred cycles
    initial begin
        #200000;
        error_cnt++;
        $display("Watchdog expired");
        results;
    end
endmodule
bind tfac_checker tfac_checker_chk #(.TC_W(TC_W)) u_chk (.*);
`default_nettype wire
